//--- tape_ctrl_pkg.sv
/*
 * Shared constants and types of the tape controller host register port.
 * Assumes a single 40 MHz clock domain and the host bus pins of the board.
 */
// What this block does
// [RULE_01] Eight word-wide host registers carry all host to controller traffic.
// [RULE_02] Registers sit at even addresses 40H to 4EH in the fixed order.
// [RULE_03] Vector low byte is host vector, high byte carries controller flags.
// [RULE_04] A command word written by the host is accepted and executed; one written while the 32-entry FIFO is full is dropped and flagged.
// [RULE_05] Status register reports selected drive and controller state.
// [RULE_06] Second status bits 3 to 0 give retries of the last read or write.
// [RULE_07] Second status upper byte gives blocks or files passed in a skip.
// [RULE_08] Last register is master interrupt control gating host interrupts.
// [RULE_09] Controller issues drive address, track and motion commands to drive.
// [RULE_10] The selected drive returns status over the drive interface.
// [RULE_11] Decoder compares address bits 15 to 4 with straps, 15 to 7 low; the code compares bits 15 to 7 with base_strap too, not with zero.
// [RULE_12] By default bit 6 is expected high and bits 5 and 4 low.
// [RULE_13] Board-enable strap gates the decoder; disabled board ignores all.
// [RULE_14] Host loads DMA address and length before a transfer command.
package tape_ctrl_pkg;

	// ========================================
	// Register map
	localparam logic [7:0] REG_VECTOR = 8'h40;
	localparam logic [7:0] REG_COMMAND = 8'h42;
	localparam logic [7:0] REG_DMA_LOW = 8'h44;
	localparam logic [7:0] REG_DMA_HIGH = 8'h46;
	localparam logic [7:0] REG_DMA_LEN = 8'h48;
	localparam logic [7:0] REG_STATUS = 8'h4A;
	localparam logic [7:0] REG_COUNTS = 8'h4C;
	localparam logic [7:0] REG_MIC = 8'h4E;

	// ========================================
	// Reset values and field positions
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0] VECTOR_RESET = 8'h00;
	localparam logic [11:0] BASE_STRAP_DEFAULT = 12'h004;
	localparam logic BOARD_ENABLE_DEFAULT = 1'b1;
	localparam int MIE_BIT = 0;
	localparam int FLAG_BUSY = 1;
	localparam int FLAG_CMDREJ = 2;
	localparam int FIFO_DEPTH = 32;
	localparam int WORD_WIDTH = 16;

	// ========================================
	// Command opcodes in the low byte of a command word
	localparam logic [7:0] OP_SELECT = 8'h0B;
	localparam logic [7:0] OP_TRACK = 8'h0E;
	localparam logic [7:0] OP_MOTION_FIRST = 8'h01;
	localparam logic [7:0] OP_MOTION_LAST = 8'h0A;

	// ========================================
	// Carriers
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} host_bus_type;

	typedef struct packed {
		logic [7:0] high;
		logic [15:0] low;
		logic [15:0] length;
	} dma_param_type;

	typedef struct packed {
		logic [1:0] unit;
		logic [1:0] track;
		logic [3:0] motion;
	} drive_cmd_type;

endpackage

//--- tape_ctrl_host_register_port.sv
/*
 * Host register port of the cartridge tape controller with its command FIFO.
 * Assumes host bus pins and straps are asynchronous to clk and are
 * synchronised here; the controller core and drive logic run on clk.
 */
`timescale 1ns/1ps

// ========================================
// Command FIFO
module cmd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	always_comb begin
		in_ready = (count != (AW+1)'(DEPTH));
		out_valid = (count != '0);
		out_data = mem[rd_ptr];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

// ========================================
// Register port
module tape_ctrl_host_register_port (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Host bus pins
	input wire logic [15:0] sys_addr,
	input wire logic sys_rd_n,
	input wire logic sys_wr_n,
	input wire logic [15:0] sys_wdata,
	output logic [15:0] sys_rdata,
	output logic sys_rdata_oe,
	// Board straps
	input wire logic [11:0] base_strap,
	input wire logic board_enable,
	// Controller core
	input wire logic [6:0] core_flags,
	input wire logic [3:0] retry_count,
	input wire logic [7:0] skip_count,
	input wire logic core_irq_req,
	output logic host_irq,
	output tape_ctrl_pkg::dma_param_type dma_param,
	output logic [15:0] core_cmd,
	output logic core_cmd_valid,
	input wire logic core_cmd_ready,
	// Drive interface
	output tape_ctrl_pkg::drive_cmd_type drive_cmd,
	output logic drive_cmd_strobe,
	input wire logic [11:0] drive_status
);

	function automatic logic in_range(input logic [7:0] op);
		in_range = (op >= tape_ctrl_pkg::OP_MOTION_FIRST) &&
			(op <= tape_ctrl_pkg::OP_MOTION_LAST);
	endfunction

	// ========================================
	// Synchronisers
	tape_ctrl_pkg::host_bus_type bus_s1, bus_s2, bus_raw;
	logic [11:0] strap_s1, strap_s2, dstat_s1, dstat_s2;
	logic en_s1, en_s2, wr_d, rd_d;

	assign bus_raw = '{rd: !sys_rd_n, wr: !sys_wr_n, addr: sys_addr,
		wdata: sys_wdata};

	always_ff @(posedge clk) begin
		if (!rstn) begin
			bus_s1 <= '0;
			bus_s2 <= '0;
			strap_s1 <= tape_ctrl_pkg::BASE_STRAP_DEFAULT;
			strap_s2 <= tape_ctrl_pkg::BASE_STRAP_DEFAULT;
			en_s1 <= tape_ctrl_pkg::BOARD_ENABLE_DEFAULT;
			en_s2 <= tape_ctrl_pkg::BOARD_ENABLE_DEFAULT;
			dstat_s1 <= '0;
			dstat_s2 <= '0;
			wr_d <= 1'b0;
			rd_d <= 1'b0;
		end else begin
			bus_s1 <= bus_raw;
			bus_s2 <= bus_s1;
			strap_s1 <= base_strap;
			strap_s2 <= strap_s1;
			en_s1 <= board_enable;
			en_s2 <= en_s1;
			dstat_s1 <= drive_status;
			dstat_s2 <= dstat_s1; // RULE_10
			wr_d <= bus_s2.wr;
			rd_d <= bus_s2.rd;
		end
	end

	// ========================================
	// Address decode
	// Straps are taken once, in the first cycles after reset, because a
	// strap that moved under a running host would relocate the board.
	logic [11:0] base, next_base;
	logic board_on, next_board_on, strap_done, next_strap_done;
	logic [1:0] strap_wait, next_strap_wait;
	logic hit, wr_take, rd_active;
	logic [3:0] reg_ofs;

	always_comb begin
		next_strap_wait = strap_wait;
		next_strap_done = strap_done;
		next_base = base;
		next_board_on = board_on;
		if (!strap_done) begin
			next_strap_wait = strap_wait + 2'h1;
			if (strap_wait == 2'h3) begin
				next_base = strap_s2;
				next_board_on = en_s2;
				next_strap_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			base <= tape_ctrl_pkg::BASE_STRAP_DEFAULT; // RULE_11 RULE_12
			board_on <= tape_ctrl_pkg::BOARD_ENABLE_DEFAULT;
			strap_done <= 1'b0;
			strap_wait <= 2'h0;
		end else begin
			base <= next_base;
			board_on <= next_board_on;
			strap_done <= next_strap_done;
			strap_wait <= next_strap_wait;
		end
	end

	always_comb begin
		reg_ofs = bus_s2.addr[3:0];
		hit = strap_done && board_on && // RULE_13
			(bus_s2.addr[15:4] == base) && !bus_s2.addr[0]; // RULE_11
		wr_take = hit && bus_s2.wr && !wr_d;
		rd_active = hit && bus_s2.rd;
	end

	// ========================================
	// Host registers
	logic [7:0] vector, next_vector;
	logic [15:0] next_core_cmd;
	logic mie, next_mie, cmd_lost, next_cmd_lost;
	tape_ctrl_pkg::dma_param_type next_dma;
	logic fifo_in_ready, fifo_out_valid, cmd_push;
	logic [15:0] fifo_out_data;
	logic [7:0] flags_hi;
	logic [15:0] status_word, counts_word, next_rdata;
	logic next_oe, next_irq;

	assign cmd_push = wr_take && (reg_ofs == tape_ctrl_pkg::REG_COMMAND[3:0]);

	always_comb begin
		next_vector = vector;
		next_dma = dma_param;
		next_mie = mie;
		// A refused command stays flagged until the host rewrites the
		// vector; a new refusal in that cycle still wins.
		next_cmd_lost = cmd_lost;
		if (wr_take) begin
			case (reg_ofs)
			tape_ctrl_pkg::REG_VECTOR[3:0]: begin
				next_vector = bus_s2.wdata[7:0]; // RULE_03
				next_cmd_lost = 1'b0;
			end
			tape_ctrl_pkg::REG_DMA_LOW[3:0]: begin
				next_dma.low = bus_s2.wdata; // RULE_14
			end
			tape_ctrl_pkg::REG_DMA_HIGH[3:0]: begin
				next_dma.high = bus_s2.wdata[7:0];
			end
			tape_ctrl_pkg::REG_DMA_LEN[3:0]: begin
				next_dma.length = bus_s2.wdata;
			end
			tape_ctrl_pkg::REG_MIC[3:0]: begin
				next_mie = bus_s2.wdata[tape_ctrl_pkg::MIE_BIT]; // RULE_08
			end
			default: begin
			end
			endcase
		end
		if (cmd_push && !fifo_in_ready) begin
			next_cmd_lost = 1'b1;
		end
		next_irq = mie && core_irq_req; // RULE_08
	end

	always_comb begin
		flags_hi = {1'b0, core_flags};
		flags_hi[tape_ctrl_pkg::FLAG_BUSY] =
			core_flags[tape_ctrl_pkg::FLAG_BUSY] || fifo_out_valid;
		flags_hi[tape_ctrl_pkg::FLAG_CMDREJ] =
			core_flags[tape_ctrl_pkg::FLAG_CMDREJ] || cmd_lost;
		status_word = {drive_cmd.track, drive_cmd.unit, dstat_s2}; // RULE_05
		counts_word = {skip_count, 4'h0, retry_count}; // RULE_06 RULE_07
		next_oe = rd_active;
		next_rdata = sys_rdata;
		if (rd_active) begin
			case (reg_ofs) // RULE_01 RULE_02
			tape_ctrl_pkg::REG_VECTOR[3:0]: next_rdata = {flags_hi, vector};
			tape_ctrl_pkg::REG_COMMAND[3:0]: next_rdata = core_cmd;
			tape_ctrl_pkg::REG_DMA_LOW[3:0]: next_rdata = dma_param.low;
			tape_ctrl_pkg::REG_DMA_HIGH[3:0]: begin
				next_rdata = {8'h00, dma_param.high};
			end
			tape_ctrl_pkg::REG_DMA_LEN[3:0]: next_rdata = dma_param.length;
			tape_ctrl_pkg::REG_STATUS[3:0]: next_rdata = status_word;
			tape_ctrl_pkg::REG_COUNTS[3:0]: next_rdata = counts_word;
			tape_ctrl_pkg::REG_MIC[3:0]: next_rdata = {15'h0000, mie};
			default: next_rdata = tape_ctrl_pkg::WORD_RESET;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			vector <= tape_ctrl_pkg::VECTOR_RESET;
			dma_param <= '0;
			mie <= 1'b0;
			cmd_lost <= 1'b0;
			sys_rdata <= tape_ctrl_pkg::WORD_RESET;
			sys_rdata_oe <= 1'b0;
			host_irq <= 1'b0;
		end else begin
			vector <= next_vector;
			dma_param <= next_dma;
			mie <= next_mie;
			cmd_lost <= next_cmd_lost;
			sys_rdata <= next_rdata;
			sys_rdata_oe <= next_oe;
			host_irq <= next_irq;
		end
	end

	// ========================================
	// Command path to the core and the drive
	cmd_fifo #(
		.WIDTH(tape_ctrl_pkg::WORD_WIDTH),
		.DEPTH(tape_ctrl_pkg::FIFO_DEPTH)
	) u_cmd_fifo (
		.clk(clk),
		.rstn(rstn),
		.in_valid(cmd_push), // RULE_04
		.in_ready(fifo_in_ready),
		.in_data(bus_s2.wdata),
		.out_valid(fifo_out_valid),
		.out_ready(core_cmd_ready),
		.out_data(fifo_out_data)
	);

	tape_ctrl_pkg::drive_cmd_type next_drive_cmd;
	logic pop, next_cmd_valid, next_strobe;
	logic [7:0] op;

	always_comb begin
		pop = fifo_out_valid && core_cmd_ready;
		op = fifo_out_data[7:0];
		next_core_cmd = core_cmd;
		next_cmd_valid = pop;
		next_drive_cmd = drive_cmd;
		next_strobe = 1'b0;
		if (pop) begin
			next_core_cmd = fifo_out_data; // RULE_04
			if (op == tape_ctrl_pkg::OP_SELECT) begin
				next_drive_cmd.unit = fifo_out_data[9:8]; // RULE_09
				next_strobe = 1'b1;
			end else if (op == tape_ctrl_pkg::OP_TRACK) begin
				next_drive_cmd.track = fifo_out_data[9:8]; // RULE_09
				next_strobe = 1'b1;
			end else if (in_range(op)) begin
				next_drive_cmd.motion = op[3:0]; // RULE_09
				next_strobe = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			core_cmd <= tape_ctrl_pkg::WORD_RESET;
			core_cmd_valid <= 1'b0;
			drive_cmd <= '0;
			drive_cmd_strobe <= 1'b0;
		end else begin
			core_cmd <= next_core_cmd;
			core_cmd_valid <= next_cmd_valid;
			drive_cmd <= next_drive_cmd;
			drive_cmd_strobe <= next_strobe;
		end
	end
endmodule

//--- host_cpu_model.sv
/* Host CPU model: drives the board's bus pins and takes its answers.
   Assumes the bench clock and a register port that answers in 3 edges. */
`timescale 1ns/1ps
// ========================================
// Host bus master
module host_cpu_model (
	// Clock
	input wire logic clk,
	// Bus pins
	output logic [15:0] sys_addr,
	output logic sys_rd_n,
	output logic sys_wr_n,
	output logic [15:0] sys_wdata,
	input wire logic [15:0] sys_rdata,
	input wire logic sys_rdata_oe
);
	initial begin
		sys_addr = 16'h0000;
		sys_rd_n = 1'b1;
		sys_wr_n = 1'b1;
		sys_wdata = 16'hFFFF;
	end
	// Write strobes stand four cycles and gaps four, above the port's minimum.
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		sys_addr = a;
		sys_wdata = d;
		sys_wr_n = 1'b0;
		repeat (4) @(negedge clk);
		sys_wr_n = 1'b1;
		// Released data shows the inverse, so a stale word cannot pass.
		sys_wdata = ~d;
		repeat (4) @(negedge clk);
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d,
		output logic hit);
		int n;
		@(negedge clk);
		sys_addr = a;
		sys_rd_n = 1'b0;
		hit = 1'b0;
		d = 16'h0000;
		// Answers are looked at on the falling edge, where they have settled.
		for (n = 0; n < 6 && !hit; n++) begin
			@(negedge clk);
			hit = sys_rdata_oe === 1'b1;
			d = sys_rdata;
		end
		@(negedge clk);
		sys_rd_n = 1'b1;
		repeat (5) @(negedge clk);
	endtask
endmodule

//--- tape_ctrl_host_register_port_checker.sv
/* Checker of the register port's timing relations at its own pins.
   Assumes one clock domain and the synchronous active-low reset. */
`timescale 1ns/1ps
// ========================================
// Checker
module tape_ctrl_host_register_port_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Host bus pins
	input wire logic sys_rd_n,
	input wire logic sys_wr_n,
	input wire logic sys_rdata_oe,
	// Controller core
	input wire logic core_irq_req,
	input wire logic host_irq,
	input wire tape_ctrl_pkg::dma_param_type dma_param,
	input wire logic [15:0] core_cmd,
	input wire logic core_cmd_valid,
	input wire logic core_cmd_ready,
	// Drive interface
	input wire tape_ctrl_pkg::drive_cmd_type drive_cmd,
	input wire logic drive_cmd_strobe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_read_to_oe: assert property (
		$rose(sys_rdata_oe) |-> $past(!sys_rd_n, 2))
		else $error("read data enabled without a read");
	a_oe_release: assert property (
		$rose(sys_rd_n) |-> ##[1:4] !sys_rdata_oe)
		else $error("read data still driven after read ended");
	a_dma_by_write: assert property (
		$changed(dma_param) |-> $past(!sys_wr_n))
		else $error("dma parameters moved without a write");
	a_irq_source: assert property (
		host_irq |-> $past(core_irq_req))
		else $error("host interrupt without core request");
	a_pop_to_valid: assert property (
		core_cmd_valid |-> $past(core_cmd_ready))
		else $error("command valid without a pop");
	a_cmd_word_hold: assert property (
		!core_cmd_valid |-> $stable(core_cmd))
		else $error("command word moved between pops");
	a_select_unit: assert property (
		core_cmd_valid && core_cmd[7:0] == tape_ctrl_pkg::OP_SELECT |->
		drive_cmd_strobe && drive_cmd.unit == core_cmd[9:8])
		else $error("select command not sent to drive");
	a_track_set: assert property (
		core_cmd_valid && core_cmd[7:0] == tape_ctrl_pkg::OP_TRACK |->
		drive_cmd_strobe && drive_cmd.track == core_cmd[9:8])
		else $error("track command not sent to drive");
	a_motion_set: assert property (
		core_cmd_valid &&
		core_cmd[7:0] >= tape_ctrl_pkg::OP_MOTION_FIRST &&
		core_cmd[7:0] <= tape_ctrl_pkg::OP_MOTION_LAST |->
		drive_cmd_strobe && drive_cmd.motion == core_cmd[3:0])
		else $error("motion command not sent to drive");
	a_strobe_cause: assert property (
		drive_cmd_strobe |-> core_cmd_valid)
		else $error("drive strobe without a command");
	a_drive_hold: assert property (
		!drive_cmd_strobe |-> $stable(drive_cmd))
		else $error("drive command moved without strobe");
endmodule
bind tape_ctrl_host_register_port tape_ctrl_host_register_port_checker chk_u (
	.clk(clk), .rstn(rstn), .sys_rd_n(sys_rd_n), .sys_wr_n(sys_wr_n),
	.sys_rdata_oe(sys_rdata_oe), .core_irq_req(core_irq_req),
	.host_irq(host_irq), .dma_param(dma_param), .core_cmd(core_cmd),
	.core_cmd_valid(core_cmd_valid), .core_cmd_ready(core_cmd_ready),
	.drive_cmd(drive_cmd), .drive_cmd_strobe(drive_cmd_strobe));

//--- tape_ctrl_host_register_port_tb_top.sv
/* Self-checking testbench of the host register port.
   Assumes package, design, checker and host model are compiled before it. */
`timescale 1ns/1ps
module tape_ctrl_host_register_port_tb_top;
	logic clk, rstn, sys_rd_n, sys_wr_n, sys_rdata_oe, board_enable;
	logic core_irq_req, host_irq, core_cmd_valid, core_cmd_ready;
	logic drive_cmd_strobe;
	logic [15:0] sys_addr, sys_wdata, sys_rdata, core_cmd;
	logic [11:0] base_strap, drive_status;
	logic [6:0] core_flags;
	logic [3:0] retry_count;
	logic [7:0] skip_count;
	tape_ctrl_pkg::dma_param_type dma_param;
	tape_ctrl_pkg::drive_cmd_type drive_cmd;
	int errors = 0, num_checks = 0, cycles = 0;
	tape_ctrl_host_register_port dut_u (.clk(clk), .rstn(rstn),
		.sys_addr(sys_addr), .sys_rd_n(sys_rd_n), .sys_wr_n(sys_wr_n),
		.sys_wdata(sys_wdata), .sys_rdata(sys_rdata),
		.sys_rdata_oe(sys_rdata_oe), .base_strap(base_strap),
		.board_enable(board_enable), .core_flags(core_flags),
		.retry_count(retry_count), .skip_count(skip_count),
		.core_irq_req(core_irq_req), .host_irq(host_irq),
		.dma_param(dma_param), .core_cmd(core_cmd),
		.core_cmd_valid(core_cmd_valid), .core_cmd_ready(core_cmd_ready),
		.drive_cmd(drive_cmd), .drive_cmd_strobe(drive_cmd_strobe),
		.drive_status(drive_status));
	host_cpu_model host_u (.clk(clk), .sys_addr(sys_addr),
		.sys_rd_n(sys_rd_n), .sys_wr_n(sys_wr_n), .sys_wdata(sys_wdata),
		.sys_rdata(sys_rdata), .sys_rdata_oe(sys_rdata_oe));
	// ========================================
	// Shared tasks
	task automatic chk(input string nm, input logic [39:0] e,
		input logic [39:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic hit;
		host_u.rd(a, d, hit);
		chk($sformatf("answer at %h", a), 40'h1, {39'h0, hit});
		chk($sformatf("word at %h", a), {24'h0, e}, {24'h0, d});
	endtask
	task automatic do_reset();
		rstn = 1'b0;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		repeat (8) @(negedge clk);
	endtask
	// Counts command pops over a fixed window with the core always ready.
	task automatic drain(input int win, output int n);
		n = 0;
		core_cmd_ready = 1'b1;
		repeat (win) begin
			@(negedge clk);
			if (core_cmd_valid === 1'b1) n++;
		end
		core_cmd_ready = 1'b0;
	endtask
	// ========================================
	// Scenarios
	task automatic t_map();
		host_u.wr(16'h0044, 16'h1234);
		host_u.wr(16'h0046, 16'h0056);
		host_u.wr(16'h0048, 16'h0400);
		chk("dma_param", 40'h5612340400, dma_param);
		rdchk(16'h0044, 16'h1234);
		rdchk(16'h0048, 16'h0400);
		host_u.wr(16'h004A, 16'hFFFF);
		host_u.wr(16'h004C, 16'hFFFF);
		rdchk(16'h004A, 16'h0A5C);
		rdchk(16'h004C, 16'h9C07);
		host_u.wr(16'h0040, 16'hFFA5);
		rdchk(16'h0040, 16'h79A5);
		$display("test map done");
	endtask
	task automatic t_decode();
		logic [15:0] miss [4] = '{16'h1044, 16'h0054, 16'h0004, 16'h0045};
		logic [15:0] d;
		logic hit;
		foreach (miss[i]) host_u.wr(miss[i], 16'hBEEF);
		chk("dma_param", 40'h5612340400, dma_param);
		host_u.rd(16'h1044, d, hit);
		chk("miss answer", 40'h0, {39'h0, hit});
		board_enable = 1'b0;
		do_reset();
		host_u.wr(16'h0048, 16'h0123);
		host_u.rd(16'h0048, d, hit);
		chk("disabled answer", 40'h0, {39'h0, hit});
		chk("disabled dma", 40'h0, dma_param);
		board_enable = 1'b1;
		base_strap = 12'h804;
		do_reset();
		host_u.wr(16'h8048, 16'h0123);
		chk("moved base", 40'h0000000123, dma_param);
		base_strap = 12'h004;
		do_reset();
		$display("test decode done");
	endtask
	task automatic t_cmd();
		int n;
		host_u.wr(16'h0042, 16'h020B);
		host_u.wr(16'h0042, 16'h030E);
		host_u.wr(16'h0042, 16'h0001);
		rdchk(16'h0040, 16'h7B00);
		drain(8, n);
		chk("pops", 40'h3, 40'(n));
		chk("unit", 40'h2, {38'h0, drive_cmd.unit});
		chk("track", 40'h3, {38'h0, drive_cmd.track});
		chk("motion", 40'h1, {36'h0, drive_cmd.motion});
		rdchk(16'h004A, 16'hEA5C);
		rdchk(16'h0042, 16'h0001);
		$display("test command done");
	endtask
	task automatic t_full();
		int n;
		repeat (33) host_u.wr(16'h0042, 16'h0000);
		rdchk(16'h0040, 16'h7F00);
		host_u.wr(16'h0040, 16'h0000);
		rdchk(16'h0040, 16'h7B00);
		drain(48, n);
		chk("drained", 40'h20, 40'(n));
		$display("test full done");
	endtask
	task automatic t_irq();
		core_irq_req = 1'b1;
		host_u.wr(16'h004E, 16'h0001);
		chk("irq on", 40'h1, {39'h0, host_irq});
		rdchk(16'h004E, 16'h0001);
		host_u.wr(16'h004E, 16'h0000);
		chk("irq off", 40'h0, {39'h0, host_irq});
		core_irq_req = 1'b0;
		$display("test irq done");
	endtask
	// ========================================
	// Run control
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		// The scenarios need about seven hundred cycles; this leaves margin.
		if (cycles == 4000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		rstn = 1'b0;
		base_strap = 12'h004;
		board_enable = 1'b1;
		core_flags = 7'h79;
		retry_count = 4'h7;
		skip_count = 8'h9C;
		core_irq_req = 1'b0;
		core_cmd_ready = 1'b0;
		drive_status = 12'hA5C;
		do_reset();
		t_map();
		t_decode();
		t_cmd();
		t_full();
		t_irq();
		print_verdict();
	end
endmodule
